// ===== rtl/irq_cmd_regs.sv
// command, status, debug and fast-forcing registers of the vectored irq unit
//
// Operation
// RQ1 - disable command clears enable bits written one
// RQ2 - clear command drops pending of written ones
// RQ3 - set command makes written ones pending
// RQ4 - handler writes end-of-service when treatment done
// RQ5 - any end-of-service write signals completion
// RQ6 - spurious vector returned on spurious vector reads
// RQ7 - debug bit zero selects protection mode
// RQ8 - debug bit one holds request lines inactive
// RQ9 - forcing enable sets forcing for written ones; bit 0 (fast source) is masked by FF_VALID and never set
// RQ10 - forcing disable clears forcing for written ones
// RQ11 - forcing state reads current forcing bits
// RQ12 - enable mask readable, one means enabled
// RQ13 - pending state readable, one means pending
// RQ14 - read-only writes ignored, write-only reads zero
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
module irq_cmd_regs
  import irq_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NSRC-1:0] src_event,
  input wire logic normal_request_in,
  input wire logic fast_request_in,
  input wire logic current_valid,
  input wire logic [4:0] current_id,
  input wire logic [DATA_W-1:0] current_vector,
  input wire logic [DATA_W-1:0] fast_source_vector,
  output logic [NSRC-1:0] source_enable_mask,
  output logic [NSRC-1:0] source_pending_state,
  output logic [NSRC-1:0] fast_forcing_state,
  output logic protection_mode,
  output logic end_of_service,
  output logic vector_read,
  output logic normal_request_line_n,
  output logic fast_request_line_n,
  output logic irq
);
  reg_req_t req;
  logic [NSRC-1:0] enable_r, enable_nxt;
  logic [NSRC-1:0] pend_r, pend_nxt;
  logic [NSRC-1:0] ff_r, ff_nxt;
  logic [DATA_W-1:0] spu_r;
  logic [1:0] dbg_r;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [NEV-1:0] ev_stat_r, ev_stat_nxt, ev_mask_r, ev_set;
  logic eos_r;
  logic [1:0] normal_request_line_sync_r, fast_request_line_sync_r;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  wire wr_enable = req.wr && req.addr == OFS_ENABLE_CMD;
  wire wr_disable = req.wr && req.addr == OFS_DISABLE_CMD;
  wire wr_clear = req.wr && req.addr == OFS_CLEAR_CMD;
  wire wr_set = req.wr && req.addr == OFS_SET_CMD;
  wire wr_eos = req.wr && req.addr == OFS_END_OF_SERVICE;
  wire wr_spu = req.wr && req.addr == OFS_SPURIOUS_VECTOR;
  wire wr_dbg = req.wr && req.addr == OFS_DEBUG_CONTROL;
  wire wr_ffen = req.wr && req.addr == OFS_FF_ENABLE;
  wire wr_ffdis = req.wr && req.addr == OFS_FF_DISABLE;
  wire wr_mask = req.wr && req.addr == OFS_IRQ_MASK;
  wire rd_nvec = req.rd && req.addr == OFS_NORMAL_VECTOR;
  wire rd_fvec = req.rd && req.addr == OFS_FAST_VECTOR;
  wire rd_stat = req.rd && req.addr == OFS_IRQ_STATUS;

  // a spurious read is a vector read with nothing to serve
  wire spurious_normal = rd_nvec && !current_valid;
  wire spurious_fast = rd_fvec && !pend_r[FAST_SOURCE_BIT];

  wire [NSRC-1:0] en_set = wr_enable ? req.wdata : RST_SRC;
  wire [NSRC-1:0] en_clr = wr_disable ? req.wdata : RST_SRC;
  wire [NSRC-1:0] pd_set = (wr_set ? req.wdata : RST_SRC) | src_event;
  wire [NSRC-1:0] pd_clr = wr_clear ? req.wdata : RST_SRC;
  wire [NSRC-1:0] ff_set = wr_ffen ? (req.wdata & FF_VALID) : RST_SRC;
  wire [NSRC-1:0] ff_clr = wr_ffdis ? (req.wdata & FF_VALID) : RST_SRC;

  // per-source update; a hardware event beats a software clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_src
      assign enable_nxt[i] = en_set[i] | (enable_r[i] & ~en_clr[i]); // see RQ1
      assign pend_nxt[i] = pd_set[i] | (pend_r[i] & ~pd_clr[i]); // see RQ2 see RQ3
      assign ff_nxt[i] = ff_set[i] | (ff_r[i] & ~ff_clr[i]); // see RQ9 see RQ10
    end
  endgenerate

  assign ev_set[EV_END_OF_SERVICE] = wr_eos;
  assign ev_set[EV_SPURIOUS] = spurious_normal | spurious_fast;
  // set wins over the clear-on-read
  assign ev_stat_nxt = ev_set | (rd_stat ? RST_EV : ev_stat_r);

  always_comb begin
    rdata_nxt = '0; // see RQ14
    unique case (1'b1)
      req.rd && req.addr == OFS_ENABLE_MASK: rdata_nxt = enable_r; // see RQ12
      req.rd && req.addr == OFS_PENDING: rdata_nxt = pend_r; // see RQ13
      req.rd && req.addr == OFS_SPURIOUS_VECTOR: rdata_nxt = spu_r;
      req.rd && req.addr == OFS_DEBUG_CONTROL: rdata_nxt = {30'h0, dbg_r};
      req.rd && req.addr == OFS_FF_STATE: rdata_nxt = ff_r; // see RQ11
      rd_nvec: rdata_nxt = current_valid ? current_vector : spu_r; // see RQ6
      rd_fvec: rdata_nxt = pend_r[FAST_SOURCE_BIT] ? fast_source_vector : spu_r; // see RQ6
      rd_stat: rdata_nxt = {30'h0, ev_stat_r};
      req.rd && req.addr == OFS_IRQ_MASK: rdata_nxt = {30'h0, ev_mask_r};
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      enable_r <= RST_SRC;
      pend_r <= RST_SRC;
      ff_r <= RST_SRC;
    end else begin
      enable_r <= enable_nxt;
      pend_r <= pend_nxt;
      ff_r <= ff_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      spu_r <= RST_SPURIOUS_VECTOR;
      dbg_r <= RST_DEBUG;
      ev_mask_r <= RST_EV;
    end else begin
      if (wr_spu) spu_r <= req.wdata;
      if (wr_dbg) dbg_r <= req.wdata[1:0]; // see RQ7 see RQ8
      if (wr_mask) ev_mask_r <= req.wdata[NEV-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_r <= '0;
      ev_stat_r <= RST_EV;
      eos_r <= 1'b0;
      normal_request_line_sync_r <= 2'h3;
      fast_request_line_sync_r <= 2'h3;
    end else begin
      rdata_r <= rdata_nxt;
      ev_stat_r <= ev_stat_nxt;
      eos_r <= wr_eos; // see RQ5
      normal_request_line_sync_r <= {normal_request_line_sync_r[0], ~normal_request_in};
      fast_request_line_sync_r <= {fast_request_line_sync_r[0], ~fast_request_in};
    end
  end

  assign reg_rdata = rdata_r;
  assign source_enable_mask = enable_r;
  assign source_pending_state = pend_r;
  assign fast_forcing_state = ff_r;
  assign protection_mode = dbg_r[PROTECTION_MODE_BIT]; // see RQ7
  assign end_of_service = eos_r;
  // in protection mode a vector read reports no side effect downstream
  assign vector_read = (rd_nvec | rd_fvec) & ~dbg_r[PROTECTION_MODE_BIT];
  // request lines are active low; the global mask ties them high
  assign normal_request_line_n = normal_request_line_sync_r[1] | dbg_r[GLOBAL_LINE_MASK_BIT]; // see RQ8
  assign fast_request_line_n = fast_request_line_sync_r[1] | dbg_r[GLOBAL_LINE_MASK_BIT]; // see RQ8
  assign irq = |(ev_stat_r & ev_mask_r);
endmodule

// ===== rtl/irq_cmd_pkg.sv
// shared constants and types for the interrupt command and forcing registers
package irq_cmd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NSRC = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CLEAR_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SET_CMD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_END_OF_SERVICE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SPURIOUS_VECTOR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_DEBUG_CONTROL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FF_ENABLE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FF_DISABLE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_FF_STATE = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_VECTOR = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_FAST_VECTOR = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h3C;
  // field positions
  localparam int FAST_SOURCE_BIT = 0;
  localparam int SYSTEM_SOURCE_BIT = 1;
  localparam int PROTECTION_MODE_BIT = 0;
  localparam int GLOBAL_LINE_MASK_BIT = 1;
  localparam int EV_END_OF_SERVICE = 0;
  localparam int EV_SPURIOUS = 1;
  localparam int NEV = 2;
  // reset values and the forcing valid mask
  localparam logic [DATA_W-1:0] RST_SPURIOUS_VECTOR = 32'h0000_0000;
  localparam logic [1:0] RST_DEBUG = 2'h0;
  localparam logic [NSRC-1:0] RST_SRC = 32'h0000_0000;
  localparam logic [NSRC-1:0] FF_VALID = 32'hFFFF_FFFE;
  localparam logic [NEV-1:0] RST_EV = 2'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;
endpackage

// ===== dv/irq_cmd_regs_assertions.sv
// port assertions for the command and forcing registers
`timescale 1ns/100ps
module irq_cmd_regs_chk
  import irq_cmd_pkg::*;
(
  input wire logic core_clk, nrst, reg_wr, reg_rd, protection_mode, end_of_service,
  input wire logic normal_request_line_n, fast_request_line_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
  input wire logic [NSRC-1:0] src_event, source_enable_mask, source_pending_state, fast_forcing_state
);
  wire logic [31:0] m = source_enable_mask, p = source_pending_state, f = fast_forcing_state, w = reg_wdata;
  // one-hot word decode; misaligned or high addresses select nothing
  wire logic ok = reg_addr < 8'h40 && reg_addr[1:0] == 2'h0;
  wire logic [15:0] wa = reg_wr && ok ? 16'h1 << reg_addr[5:2] : 16'h0;
  wire logic [15:0] ra = reg_rd && ok ? 16'h1 << reg_addr[5:2] : 16'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_DISABLE: assert property (wa[1] |=> m == ($past(m) & ~$past(w))) else $error("disable");
  AST_CLEAR: assert property (wa[4] |=> p == ($past(p) & ~$past(w) | $past(src_event))) else $error("clear");
  AST_SET: assert property (wa[5] |=> (p & $past(w)) == $past(w)) else $error("set");
  AST_EOS: assert property (wa[6] |=> end_of_service) else $error("end of service");
  AST_PROTECTION_MODE_BIT: assert property (wa[8] |=> protection_mode == $past(w[0])) else $error("protection");
  AST_GLOBAL_LINE_MASK_BIT: assert property (wa[8] && w[1] |=> ##[0:1] normal_request_line_n && fast_request_line_n)
    else $error("line mask");
  AST_FFEN: assert property (wa[9] |=> f == (($past(f) | $past(w)) & FF_VALID)) else $error("ff on");
  AST_FFDIS: assert property (wa[10] |=> f == ($past(f) & ~$past(w))) else $error("ff off");
  AST_MASK: assert property (ra[2] |=> reg_rdata == $past(m)) else $error("mask read");
  AST_WO: assert property (ra[1] || ra[5] |=> reg_rdata == 32'h0) else $error("wo read");
  COV_EOS: cover property (wa[6]);
  COV_GLOBAL_LINE_MASK_BIT: cover property (wa[8] && w[1]);
  COV_FF: cover property (wa[10]);
endmodule
bind irq_cmd_regs irq_cmd_regs_chk chk (.*);

// ===== dv/core_line_model.sv
// processor side: counts cycles with a request line active
`timescale 1ns/100ps
module core_line_model (
  input wire logic core_clk,
  input wire logic normal_request_line_n,
  input wire logic fast_request_line_n,
  output int taken
);
  initial taken = 0;
  always @(posedge core_clk) if (!normal_request_line_n || !fast_request_line_n) taken <= taken + 1;
endmodule

// ===== dv/irq_cmd_regs_tb.sv
// self-checking bench for the command and forcing registers
`timescale 1ns/100ps
module irq_cmd_regs_tb;
  import irq_cmd_pkg::*;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, normal_request_in = 0, fast_request_in = 0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, source_enable_mask, source_pending_state, fast_forcing_state;
  logic protection_mode, end_of_service, normal_request_line_n, fast_request_line_n, irq, vector_read;
  logic current_valid = 0;
  int fails = 0, n_checks = 0, taken, t0, n_vread = 0;
  always #2 core_clk = ~core_clk;
  // vector inputs all ones so a spurious readback cannot match them by chance
  irq_cmd_regs dut (.*, .src_event(32'h0), .current_id(5'h0),
    .current_vector(32'hFFFF_FFFF), .fast_source_vector(32'hFFFF_FFFF));
  core_line_model core (.core_clk, .normal_request_line_n, .fast_request_line_n, .taken);
  // counts the vector reads that the design reports downstream
  always @(posedge core_clk) if (vector_read === 1'h1) n_vread <= n_vread + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'h1;
    reg_rd <= 1'h0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd <= 1'h1;
    reg_wr <= 1'h0;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic t_sources;
    rd(OFS_DEBUG_CONTROL, 32'h0);
    rd(OFS_SPURIOUS_VECTOR, 32'h0);
    chk({30'h0, normal_request_line_n, fast_request_line_n}, 32'h3);
    wr(OFS_ENABLE_CMD, 32'hFFFF_FFFF);
    wr(OFS_DISABLE_CMD, 32'h8000_0003);
    wr(OFS_DISABLE_CMD, 32'h0);
    wr(OFS_ENABLE_MASK, 32'h0);
    rd(OFS_ENABLE_MASK, 32'h7FFF_FFFC);
    rd(OFS_DISABLE_CMD, 32'h0);
    wr(OFS_SET_CMD, 32'h8000_0005);
    wr(OFS_CLEAR_CMD, 32'h1);
    rd(OFS_PENDING, 32'h8000_0004);
    rd(OFS_SET_CMD, 32'h0);
    $display("sources test done");
  endtask
  task automatic t_forcing;
    wr(OFS_FF_ENABLE, 32'hFFFF_FFFF);
    wr(OFS_FF_DISABLE, 32'h6);
    wr(OFS_FF_STATE, 32'h0);
    rd(OFS_FF_STATE, 32'hFFFF_FFF8);
    wr(OFS_SPURIOUS_VECTOR, 32'h1234_ABCD);
    rd(OFS_NORMAL_VECTOR, 32'h1234_ABCD);
    rd(OFS_FAST_VECTOR, 32'h1234_ABCD);
    current_valid <= 1'h1;
    wr(OFS_SET_CMD, 32'h1);
    rd(OFS_NORMAL_VECTOR, 32'hFFFF_FFFF);
    rd(OFS_FAST_VECTOR, 32'hFFFF_FFFF);
    current_valid <= 1'h0;
    wr(OFS_CLEAR_CMD, 32'h1);
    chk(n_vread, 32'h4);
    $display("forcing test done");
  endtask
  task automatic t_debug;
    wr(OFS_DEBUG_CONTROL, 32'h3);
    rd(OFS_DEBUG_CONTROL, 32'h3);
    chk({31'h0, protection_mode}, 32'h1);
    rd(OFS_NORMAL_VECTOR, 32'h1234_ABCD);
    chk(n_vread, 32'h4);
    normal_request_in <= 1'h1;
    fast_request_in <= 1'h1;
    t0 = taken;
    repeat (3) @(posedge core_clk);
    #1 chk({30'h0, normal_request_line_n, fast_request_line_n}, 32'h3);
    chk(taken, t0);
    wr(OFS_DEBUG_CONTROL, 32'h0);
    rd(OFS_DEBUG_CONTROL, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 chk({30'h0, normal_request_line_n, fast_request_line_n}, 32'h0);
    chk({31'h0, taken > t0}, 32'h1);
    normal_request_in <= 1'h0;
    fast_request_in <= 1'h0;
    $display("debug test done");
  endtask
  task automatic t_service;
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_END_OF_SERVICE, 32'hA5A5_0000);
    #1 chk({31'h0, end_of_service}, 32'h1);
    rd(OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    rd(8'h40, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h3);
    rd(OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("service test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    t_sources();
    t_forcing();
    t_debug();
    t_service();
    summarize();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    fails++;
    summarize();
  end
endmodule
